// >>> core/fprog_regs.sv
// Flash programming front end: unlock control register and data port behind the debug port
`timescale 1ns/1ps
module fprog_regs
  import fprog_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire reg_req_t     req,
  output logic [7:0]        rdata,
  output logic              prog_enabled,
  output logic              stream_valid,
  input  wire logic         stream_ready,
  output stream_word_t      stream_word,
  input  wire logic         rd_data_valid,
  input  wire logic [7:0]   rd_data,
  output logic              busy
);
  unlock_state_t unl_q;
  unlock_state_t unl_d;
  logic [7:0]    ctrl_q;
  logic [7:0]    data_q;
  logic          expect_cmd_q;
  logic [7:0]    rdata_q;
  logic          prog_q;
  logic          sv_q;
  stream_word_t  sw_q;
  logic          busy_q;

  // Command byte decode, used only for stream tagging
  function automatic flash_op_t decode_op(input logic [7:0] b);
    case (b)
      CMD_BLOCK_READ: decode_op = OP_BLOCK_READ;
      CMD_BLOCK_WR:   decode_op = OP_BLOCK_WR;
      CMD_PAGE_ERASE: decode_op = OP_PAGE_ERASE;
      CMD_DEV_ERASE:  decode_op = OP_DEV_ERASE;
      default:        decode_op = OP_BAD;
    endcase
  endfunction

  // Address decode
  wire ctrl_wr = req.wr && (req.addr == CTRL_ADDR);
  wire data_wr = req.wr && (req.addr == DATA_ADDR);
  wire ctrl_rd = req.rd && (req.addr == CTRL_ADDR);
  wire data_rd = req.rd && (req.addr == DATA_ADDR);

  // FIFO back-pressure shows as busy; writes to the data port while full are dropped
  wire fifo_in_ready;
  wire push_ok = data_wr && prog_q && fifo_in_ready;
  stream_word_t push_word;
  assign push_word.is_cmd = expect_cmd_q;
  assign push_word.op     = expect_cmd_q ? decode_op(req.wdata) : OP_NONE;
  assign push_word.data   = req.wdata;

  // Unlock sequencer; a wrong code returns to idle
  always_comb begin
    unl_d = unl_q;
    case (unl_q)
      UNL_IDLE: begin
        if (ctrl_wr && req.wdata == UNLOCK_FIRST) unl_d = UNL_FIRST;
      end
      UNL_FIRST: begin
        if (ctrl_wr) begin
          if (req.wdata == UNLOCK_SECOND) unl_d = UNL_OPEN;
          else if (req.wdata == UNLOCK_FIRST) unl_d = UNL_FIRST;
          else unl_d = UNL_IDLE;
        end
      end
      UNL_OPEN: unl_d = UNL_OPEN;
      default:  unl_d = UNL_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) unl_q <= UNL_IDLE;
    else unl_q <= unl_d;
  end

  // Programming latch: only reset clears it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) prog_q <= 1'b0;
    else if (unl_d == UNL_OPEN) prog_q <= 1'b1;
  end

  // Register storage and command/payload phase tracking
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q       <= CTRL_RESET;
      data_q       <= DATA_RESET;
      expect_cmd_q <= 1'b1;
    end else begin
      if (ctrl_wr) ctrl_q <= req.wdata;
      if (rd_data_valid) data_q <= rd_data;
      else if (push_ok) data_q <= req.wdata;
      if (push_ok) expect_cmd_q <= 1'b0;
      else if (ctrl_wr && prog_q) expect_cmd_q <= 1'b1;
    end
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rdata_q <= 8'h00;
    else if (ctrl_rd) rdata_q <= ctrl_q;
    else if (data_rd) rdata_q <= data_q;
    else if (req.rd) rdata_q <= 8'h00;
  end

  // FIFO decouples debug port writes from the slower flash engine
  stream_word_t fifo_out;
  wire          fifo_out_valid;
  wire          fifo_out_ready = !sv_q || stream_ready;
  fprog_fifo #(
    .WIDTH ($bits(stream_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (data_wr && prog_q),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out)
  );

  // Output stage registered so the engine sees flop outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sv_q   <= 1'b0;
      sw_q   <= '0;
      busy_q <= 1'b0;
    end else begin
      if (fifo_out_ready) begin
        sv_q <= fifo_out_valid;
        if (fifo_out_valid) sw_q <= fifo_out;
      end
      busy_q <= !fifo_in_ready;
    end
  end

  assign rdata        = rdata_q;
  assign prog_enabled = prog_q;
  assign stream_valid = sv_q;
  assign stream_word  = sw_q;
  assign busy         = busy_q;

  // Enable only right after the second code lands on a half-open sequencer
  a_unlock_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(prog_q) |-> $past(ctrl_wr) && $past(req.wdata) == UNLOCK_SECOND
      && $past(unl_q) == UNL_FIRST)
    else $error("programming enabled out of order");

  // Nothing but reset may leave programming mode
  a_prog_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    prog_q |=> prog_q)
    else $error("programming mode dropped without reset");

  // A foreign code throws away the first half of the sequence
  a_wrong_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (unl_q == UNL_FIRST && ctrl_wr && req.wdata != UNLOCK_SECOND && req.wdata != UNLOCK_FIRST)
      |=> unl_q == UNL_IDLE) else $error("partial unlock kept after bad code");

  // Locked data port writes never reach the FIFO
  a_locked_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (data_wr && !prog_q) |=> !fifo_out_valid || $stable(u_fifo.count_q))
    else $error("data accepted while locked");

  // Block write command tagged with its operation
  a_cmd_decode: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sv_q && sw_q.is_cmd && sw_q.data == CMD_BLOCK_WR) |-> sw_q.op == OP_BLOCK_WR)
    else $error("write command misdecoded");

  // Engine byte shows on a data port read one cycle later
  a_read_return: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_data_valid ##1 (req.rd && req.addr == DATA_ADDR) |=> rdata == $past(rd_data, 2))
    else $error("read data not returned on data port");

  // Block read command tagged with its operation
  a_read_decode: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stream_valid && stream_word.is_cmd && stream_word.data == CMD_BLOCK_READ)
      |-> stream_word.op == OP_BLOCK_READ) else $error("read command misdecoded");

  // Page erase command tagged with its operation
  a_page_decode: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stream_valid && stream_word.is_cmd && stream_word.data == CMD_PAGE_ERASE)
      |-> stream_word.op == OP_PAGE_ERASE) else $error("page erase misdecoded");

  // Device erase command tagged with its operation
  a_erase_decode: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stream_valid && stream_word.is_cmd && stream_word.data == CMD_DEV_ERASE)
      |-> stream_word.op == OP_DEV_ERASE) else $error("device erase misdecoded");

  // Payload bytes carry no operation, so the engine cannot mistake them
  a_payload_op: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stream_valid && !stream_word.is_cmd) |-> stream_word.op == OP_NONE)
    else $error("payload byte carries an operation");

  // Offered word stays put while the engine stalls
  a_stream_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stream_valid && !stream_ready) |=> stream_valid && $stable(stream_word))
    else $error("stream word changed before acceptance");

  // Busy follows a full FIFO one cycle later
  a_busy_full: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !fifo_in_ready |=> busy)
    else $error("busy missing while full");

  // Busy drops once the FIFO has room again
  a_busy_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fifo_in_ready |=> !busy)
    else $error("busy stuck with room free");

  // No stream traffic before the unlock pair
  a_locked_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !prog_enabled |-> !stream_valid)
    else $error("stream active while locked");

  // Control register reads back what was written
  a_ctrl_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctrl_rd |=> rdata == $past(ctrl_q))
    else $error("control register read mismatch");
endmodule

// >>> core/fprog_pkg.sv
// Package: register map, unlock codes, commands and carrier types for the flash programming front end
package fprog_pkg;
  localparam logic [7:0] CTRL_ADDR      = 8'h02;
  localparam logic [7:0] DATA_ADDR      = 8'hb4;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] DATA_RESET     = 8'h00;
  localparam logic [7:0] UNLOCK_FIRST   = 8'h02;
  localparam logic [7:0] UNLOCK_SECOND  = 8'h01;
  localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
  localparam logic [7:0] CMD_BLOCK_WR   = 8'h07;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
  localparam logic [7:0] CMD_DEV_ERASE  = 8'h03;
  localparam int         FIFO_WIDTH     = 8;
  localparam int         FIFO_DEPTH     = 8;

  typedef enum logic [1:0] {
    UNL_IDLE  = 2'b00,
    UNL_FIRST = 2'b01,
    UNL_OPEN  = 2'b10
  } unlock_state_t;

  typedef enum logic [2:0] {
    OP_NONE       = 3'b000,
    OP_BLOCK_READ = 3'b001,
    OP_BLOCK_WR   = 3'b010,
    OP_PAGE_ERASE = 3'b011,
    OP_DEV_ERASE  = 3'b100,
    OP_BAD        = 3'b101
  } flash_op_t;

  // One register access from the debug port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Data port byte handed to the flash engine, tagged as command or payload
  typedef struct packed {
    logic       is_cmd;
    flash_op_t  op;
    logic [7:0] data;
  } stream_word_t;
endpackage

// >>> core/fprog_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module fprog_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // Honest flags straight from the occupancy count
  assign in_ready  = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];

  // Storage has no reset; only pointers and count need a defined state
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers wrap naturally since depth is a power of two
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + AW'(1);
      if (pop) rd_ptr_q <= rd_ptr_q + AW'(1);
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> tb/fprog_engine_model.sv
// Flash engine stand-in: takes stream words, answers block reads
`timescale 1ns/1ps
module fprog_engine_model
  import fprog_pkg::*;
#(
  parameter logic [7:0] RD_BYTE = 8'h5a
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         stall,
  input  wire logic         stream_valid,
  output logic              stream_ready,
  input  wire stream_word_t stream_word,
  output logic              rd_data_valid,
  output logic [7:0]        rd_data,
  output stream_word_t      last_word,
  output int                n_acc
);
  // Stall holds words back so the FIFO fills
  assign stream_ready = !stall;
  // Junk outside the pulse, so a stale byte never looks right
  assign rd_data = rd_data_valid ? RD_BYTE : ~RD_BYTE;
  // Record accepted words; a read command returns one byte
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      n_acc <= 0;
      last_word <= '0;
      rd_data_valid <= 1'b0;
    end else begin
      rd_data_valid <= stream_valid && stream_ready && stream_word.is_cmd
                       && stream_word.op == OP_BLOCK_READ;
      if (stream_valid && stream_ready) begin
        n_acc <= n_acc + 1;
        last_word <= stream_word;
      end
    end
  end
endmodule

// >>> tb/tb_fprog_regs.sv
// Testbench for the flash programming front end
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_fprog_regs
  import fprog_pkg::*;
;
  logic         clk_sys;
  logic         rst_n;
  logic         stall;
  reg_req_t     req;
  logic [7:0]   rdata;
  logic         prog_enabled;
  logic         stream_valid;
  logic         stream_ready;
  stream_word_t stream_word;
  stream_word_t last_word;
  logic         rd_data_valid;
  logic [7:0]   rd_data;
  logic         busy;
  int           acc;
  int           miscompares = 0;
  int           n_tests = 0;
  logic [7:0]   codes[4] = '{CMD_BLOCK_READ, CMD_BLOCK_WR, CMD_PAGE_ERASE, CMD_DEV_ERASE};
  flash_op_t    ops[4] = '{OP_BLOCK_READ, OP_BLOCK_WR, OP_PAGE_ERASE, OP_DEV_ERASE};

  fprog_regs i_fprog_regs (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rdata(rdata),
    .prog_enabled(prog_enabled), .stream_valid(stream_valid), .stream_ready(stream_ready),
    .stream_word(stream_word), .rd_data_valid(rd_data_valid), .rd_data(rd_data), .busy(busy));
  fprog_engine_model i_fprog_engine_model (.clk_sys(clk_sys), .rst_n(rst_n), .stall(stall),
    .stream_valid(stream_valid), .stream_ready(stream_ready), .stream_word(stream_word),
    .rd_data_valid(rd_data_valid), .rd_data(rd_data), .last_word(last_word), .n_acc(acc));

  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // One-cycle write strobe, driven just after the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    #1 req.wr = 1'b0;
  endtask

  // Read strobe; rdata is checked just after the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    #1 req.rd = 1'b0;
    `CHK("rdata", e, rdata)
  endtask

  // Bounded wait for the engine to take one more word
  task automatic wait_acc(input int n0);
    for (int k = 0; k < 20 && acc == n0; k++) @(posedge clk_sys);
    #1 `CHK("accepted", n0 + 1, acc)
  endtask

  task automatic finish_test();
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog: the sequence needs under a microsecond
  initial begin
    #50us;
    miscompares++;
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    stall = 1'b0;
    req = '0;
    repeat (6) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    rd(CTRL_ADDR, CTRL_RESET);
    rd(8'h55, 8'h00); // Unmapped place reads zero
    wr(DATA_ADDR, CMD_BLOCK_WR);
    repeat (8) @(posedge clk_sys);
    `CHK("locked", 0, acc)
    wr(CTRL_ADDR, UNLOCK_FIRST);
    wr(CTRL_ADDR, 8'h05);
    wr(CTRL_ADDR, UNLOCK_SECOND);
    #1 `CHK("bad_seq", 1'b0, prog_enabled)
    wr(CTRL_ADDR, UNLOCK_SECOND);
    wr(CTRL_ADDR, UNLOCK_FIRST);
    #1 `CHK("rev_order", 1'b0, prog_enabled)
    wr(CTRL_ADDR, UNLOCK_SECOND);
    @(posedge clk_sys);
    #1 `CHK("unlock", 1'b1, prog_enabled)
    // Every command code, each re-armed by a control write
    for (int i = 0; i < 4; i++) begin
      wr(CTRL_ADDR, 8'h00);
      wr(DATA_ADDR, codes[i]);
      wait_acc(acc);
      `CHK("is_cmd", 1'b1, last_word.is_cmd)
      `CHK("op", ops[i], last_word.op)
    end
    wr(DATA_ADDR, 8'h3c);
    wait_acc(acc);
    `CHK("payload", {1'b0, OP_NONE, 8'h3c}, last_word)
    // Read taken the cycle after the engine byte lands, so the return check fires
    wr(CTRL_ADDR, 8'h00);
    wr(DATA_ADDR, CMD_BLOCK_READ);
    repeat (2) @(posedge clk_sys);
    rd(DATA_ADDR, 8'h5a);
    `CHK("still_on", 1'b1, prog_enabled)
    // Fill the FIFO against a stalled engine, then drain it
    stall = 1'b1;
    repeat (12) wr(DATA_ADDR, 8'h11);
    `CHK("full", 1'b1, busy)
    stall = 1'b0;
    repeat (30) @(posedge clk_sys);
    #1 `CHK("drained", 1'b0, stream_valid)
    `CHK("not_full", 1'b0, busy)
    rst_n = 1'b0;
    #1 `CHK("reset_off", 1'b0, prog_enabled)
    // After the system reset the port is locked again and needs the full pair
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    wr(CTRL_ADDR, UNLOCK_SECOND);
    wr(DATA_ADDR, CMD_DEV_ERASE);
    repeat (8) @(posedge clk_sys);
    #1 `CHK("relocked", 0, acc)
    `CHK("relock_flag", 1'b0, prog_enabled)
    finish_test();
  end
endmodule
